// File: inc/mps_pkg.sv
// mps_pkg: constants for the multiple pwm setup and start block.
// assumes a plain register port with 8-bit byte addresses, 32-bit data.
//
// Contract
// (R1) unpowered array: clock gated off, timer register writes ignored
// (R2) setting the array enable bit to 1 powers clock and writes
// (R3) after power on every channel stays stopped until started
// (R4) prescaler setting sets rates of operation clocks a and b
// (R5) mode register picks each channel's clock; channel stays stopped
// (R6) software loads period and duty values before starting
// (R7) software sets slave output mode, polarity and default level bits
// (R8) pins hi-z in setup; level shows when port output, latch 0
// (R9) enabling output drive while stopped leaves outputs unchanged
// (R10) clearing port latch and mode drives timer level onto pins
// (R11) start bits are triggers and always read back 0
// (R12) start trigger sets running flags of master and both slaves
// (R13) master start of counting raises the master period event
// (R14) slaves start counting only on the master period event
// (R15) slave loads duty, active one tick later, inactive at zero
// (R16) master counts down, at zero raises event and reloads period
package mps_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_PER_EN  = 8'h00;
  localparam logic [7:0] OFS_PRESC   = 8'h04;
  localparam logic [7:0] OFS_MODE    = 8'h08;
  localparam logic [7:0] OFS_PERIOD  = 8'h0c;
  localparam logic [7:0] OFS_DUTY1   = 8'h10;
  localparam logic [7:0] OFS_DUTY2   = 8'h14;
  localparam logic [7:0] OFS_OUTCTL  = 8'h18;
  localparam logic [7:0] OFS_PORT    = 8'h1c;
  localparam logic [7:0] OFS_START   = 8'h20;
  localparam logic [7:0] OFS_RUN     = 8'h24;
  localparam logic [7:0] OFS_MCOUNT  = 8'h28;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h30;

  // field positions
  localparam int POS_PRESC_B   = 4;  // clock b select, bits 7:4
  localparam int POS_OUT_POL   = 2;  // polarity bits 3:2
  localparam int POS_OUT_LVL   = 4;  // default level bits 5:4
  localparam int POS_OUT_DRV   = 6;  // drive enable bits 7:6
  localparam int POS_PORT_MODE = 2;  // port mode bits 3:2

  // widths
  localparam int CNT_W  = 16;
  localparam int PRE_W  = 15;

  // reset values
  localparam logic [7:0] RST_PRESC   = 8'h00;
  localparam logic [2:0] RST_MODE    = 3'h0;
  localparam logic [15:0] RST_DATA   = 16'hffff;
  localparam logic [7:0] RST_OUTCTL  = 8'h00;
  localparam logic [1:0] RST_LATCH   = 2'h0;
  localparam logic [1:0] RST_PMODE   = 2'h3;  // port pins start as input
  localparam logic [2:0] RST_IRQ     = 3'h0;

endpackage : mps_pkg

// File: rtl/mps_slave_ch.sv
// mps_slave_ch: one slave channel in one-count mode.
// assumes tick and trigger pulses are one cycle long on i_ref_clk.
`timescale 1ns/100ps
module mps_slave_ch
  import mps_pkg::*;
(
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  // control
  input  wire logic             i_pwr,
  input  wire logic             i_start,
  input  wire logic             i_tick,
  input  wire logic             i_trig,
  input  wire logic [CNT_W-1:0] i_duty,
  // status
  output logic                  o_run,
  output logic                  o_active,
  output logic                  o_end,
  output logic [CNT_W-1:0]      o_cnt
);

  logic pend;
  logic busy;

  // an event on a tick loads at once, so the output turns active one
  // count clock after the event at prescaler setting 0
  wire armed    = pend | (i_trig & o_run);
  wire load_now = armed & i_tick;
  wire at_one   = (o_cnt == 16'h0001);
  wire last_dec = busy & i_tick & ~load_now & at_one;
  wire zero_ld  = load_now & (i_duty == 16'h0000);

  // running flag only; counting waits for the master event
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~i_pwr)
      o_run <= 1'b0;                       // [R3] [R1]
    else if (i_start)
      o_run <= 1'b1;                       // [R12] [R14]
  end

  // event arms a load at the next count clock
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~i_pwr)
      pend <= 1'b0;
    else if (i_trig & o_run)
      pend <= ~i_tick;                     // [R14]
    else if (i_tick)
      pend <= 1'b0;
  end

  // down counter: load duty, halt at zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~i_pwr) begin
      o_cnt    <= 16'h0000;
      busy     <= 1'b0;
      o_active <= 1'b0;
      o_end    <= 1'b0;
    end else begin
      o_end <= last_dec | zero_ld;
      if (load_now) begin
        o_cnt    <= i_duty;                // [R15]
        busy     <= ~zero_ld;
        o_active <= ~zero_ld;              // [R15]
      end else if (busy & i_tick) begin
        o_cnt    <= o_cnt - 16'h0001;
        busy     <= ~at_one;
        o_active <= ~at_one;               // [R15]
      end
    end
  end

endmodule : mps_slave_ch

// File: rtl/mps_top.sv
// mps_top: timer array with one period master and two pwm slaves.
// assumes a register master on i_ref_clk; pins resolved outside from
// the out and output enable pairs.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module mps_top
  import mps_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // interrupt
  output logic             o_irq,
  // slave wave pins
  output logic [1:0]       o_pin_out,
  output logic [1:0]       o_pin_oe
);

  // software registers
  logic                 array_power_enable;
  logic [7:0]           clock_prescaler_select;
  logic [2:0]           channel_mode_reg;
  logic [CNT_W-1:0]     master_period_value;
  logic [CNT_W-1:0]     slave1_duty_value;
  logic [CNT_W-1:0]     slave2_duty_value;
  logic [1:0]           slave_output_mode_bit;
  logic [1:0]           output_polarity_bit;
  logic [1:0]           slave_wave_output;
  logic [1:0]           output_drive_enable;
  logic [1:0]           port_latch;
  logic [1:0]           port_mode;
  logic [2:0]           irq_status;
  logic [2:0]           irq_mask;

  // array state
  logic [PRE_W-1:0]     pre_cnt;
  logic                 master_run;
  logic [CNT_W-1:0]     channel_down_counter;
  logic                 master_period_event;
  logic [1:0]           slv_run;
  logic [1:0]           slv_active;
  logic [1:0]           slv_end;
  logic [CNT_W-1:0]     slv_cnt [2];

  // address decode
  wire sel_per   = (i_addr == OFS_PER_EN);
  wire sel_presc = (i_addr == OFS_PRESC);
  wire sel_mode  = (i_addr == OFS_MODE);
  wire sel_per_v = (i_addr == OFS_PERIOD);
  wire sel_d1    = (i_addr == OFS_DUTY1);
  wire sel_d2    = (i_addr == OFS_DUTY2);
  wire sel_out   = (i_addr == OFS_OUTCTL);
  wire sel_port  = (i_addr == OFS_PORT);
  wire sel_start = (i_addr == OFS_START);
  wire sel_run   = (i_addr == OFS_RUN);
  wire sel_mcnt  = (i_addr == OFS_MCOUNT);
  wire sel_ist   = (i_addr == OFS_IRQ_ST);
  wire sel_imsk  = (i_addr == OFS_IRQ_MSK);

  // timer writes need the array powered
  wire twr = i_wr & array_power_enable;               // [R1] [R2]

  wire wr_presc = twr & sel_presc;
  wire wr_mode  = twr & sel_mode;
  wire wr_per_v = twr & sel_per_v;
  wire wr_d1    = twr & sel_d1;
  wire wr_d2    = twr & sel_d2;
  wire wr_out   = twr & sel_out;
  wire wr_ist   = twr & sel_ist;
  wire wr_imsk  = twr & sel_imsk;
  wire wr_port  = i_wr & sel_port;  // port block is never gated

  // start triggers are never stored, so they read back 0
  wire [2:0] start_trig = (twr & sel_start) ? i_wdata[2:0] : 3'h0; // [R11]
  // master start sets only the master running flag; slaves use start bits 1 and 2
  wire       master_go  = start_trig[0];

  // prescaler: tick when the low bits are all ones
  wire [3:0]       sel_a  = clock_prescaler_select[3:0];
  wire [3:0]       sel_b  = clock_prescaler_select[POS_PRESC_B +: 4];
  wire [PRE_W-1:0] mask_a = PRE_W'((16'h0001 << sel_a) - 16'h0001);
  wire [PRE_W-1:0] mask_b = PRE_W'((16'h0001 << sel_b) - 16'h0001);
  wire tick_a = array_power_enable & ((pre_cnt & mask_a) == mask_a); // [R4]
  wire tick_b = array_power_enable & ((pre_cnt & mask_b) == mask_b); // [R4]

  // per channel clock pick from the mode register
  wire [2:0] ch_tick;
  assign ch_tick[0] = channel_mode_reg[0] ? tick_b : tick_a;  // [R5]
  assign ch_tick[1] = channel_mode_reg[1] ? tick_b : tick_a;  // [R5]
  assign ch_tick[2] = channel_mode_reg[2] ? tick_b : tick_a;  // [R5]

  // master counter decisions
  wire m_zero   = (channel_down_counter == 16'h0000);
  wire m_reload = master_run & ch_tick[0] & m_zero;

  // interrupt status; set beats a same-cycle clear
  wire [2:0] irq_set    = {slv_end, master_period_event};
  wire [2:0] irq_clr    = wr_ist ? i_wdata[2:0] : 3'h0;
  wire [2:0] next_irq_st = (irq_status & ~irq_clr) | irq_set;
  wire       next_irq    = |(next_irq_st & irq_mask);

  // hardware drives the wave bits only when enabled in slave mode;
  // drive enable alone changes nothing while stopped
  wire [1:0] hw_own = output_drive_enable & slave_output_mode_bit
                    & slv_run;                                 // [R9]
  wire [1:0] hw_lvl = slv_active ^ output_polarity_bit;        // [R15]
  wire [1:0] sw_lvl = i_wdata[POS_OUT_LVL +: 2];
  wire [1:0] next_wave;
  assign next_wave[0] = hw_own[0] ? hw_lvl[0] :
                        (wr_out ? sw_lvl[0] : slave_wave_output[0]);
  assign next_wave[1] = hw_own[1] ? hw_lvl[1] :
                        (wr_out ? sw_lvl[1] : slave_wave_output[1]);

  // pins: port output mode, latch ored with the timer level
  wire [1:0] next_pin_oe  = ~port_mode;                        // [R8]
  wire [1:0] next_pin_out = port_latch | slave_wave_output;    // [R8] [R10]

  // read mux
  wire [31:0] rd_mux =
      sel_per   ? {31'h0, array_power_enable} :
      sel_presc ? {24'h0, clock_prescaler_select} :
      sel_mode  ? {29'h0, channel_mode_reg} :
      sel_per_v ? {16'h0, master_period_value} :
      sel_d1    ? {16'h0, slave1_duty_value} :
      sel_d2    ? {16'h0, slave2_duty_value} :
      sel_out   ? {24'h0, output_drive_enable, slave_wave_output,
                   output_polarity_bit, slave_output_mode_bit} :
      sel_port  ? {28'h0, port_mode, port_latch} :
      sel_run   ? {29'h0, slv_run, master_run} :
      sel_mcnt  ? {16'h0, channel_down_counter} :
      sel_ist   ? {29'h0, irq_status} :
      sel_imsk  ? {29'h0, irq_mask} :
                  32'h0;  // start register and holes read 0

  // peripheral enable is always writable
  always_ff @(posedge i_ref_clk) begin
    if (i_rst)
      array_power_enable <= 1'b0;
    else if (i_wr & sel_per)
      array_power_enable <= i_wdata[0];                        // [R2]
  end

  // prescaler counter; held at zero while unpowered, ticks gated by the power enable
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~array_power_enable)
      pre_cnt <= '0;                                           // [R1]
    else
      pre_cnt <= pre_cnt + PRE_W'(1);
  end

  // clock and mode setup; power off reinitialises both
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~array_power_enable) begin
      clock_prescaler_select <= RST_PRESC;
      channel_mode_reg       <= RST_MODE;
    end else begin
      if (wr_presc)
        clock_prescaler_select <= i_wdata[7:0];                // [R4]
      if (wr_mode)
        channel_mode_reg <= i_wdata[2:0];                      // [R5]
    end
  end

  // period and duty data
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~array_power_enable) begin
      master_period_value <= RST_DATA;
      slave1_duty_value   <= RST_DATA;
      slave2_duty_value   <= RST_DATA;
    end else begin
      if (wr_per_v)
        master_period_value <= i_wdata[CNT_W-1:0];
      if (wr_d1)
        slave1_duty_value <= i_wdata[CNT_W-1:0];
      if (wr_d2)
        slave2_duty_value <= i_wdata[CNT_W-1:0];
    end
  end

  // output control bits
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~array_power_enable) begin
      slave_output_mode_bit <= RST_OUTCTL[1:0];
      output_polarity_bit   <= RST_OUTCTL[POS_OUT_POL +: 2];
      output_drive_enable   <= RST_OUTCTL[POS_OUT_DRV +: 2];
    end else if (wr_out) begin
      slave_output_mode_bit <= i_wdata[1:0];
      output_polarity_bit   <= i_wdata[POS_OUT_POL +: 2];
      output_drive_enable   <= i_wdata[POS_OUT_DRV +: 2];
    end
  end

  // wave output bits: software default level or live timer level
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~array_power_enable)
      slave_wave_output <= RST_OUTCTL[POS_OUT_LVL +: 2];
    else
      slave_wave_output <= next_wave;                          // [R9]
  end

  // port latch and mode belong to the port, kept across power off
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      port_latch <= RST_LATCH;
      port_mode  <= RST_PMODE;                                 // [R8]
    end else if (wr_port) begin
      port_latch <= i_wdata[1:0];                              // [R10]
      port_mode  <= i_wdata[POS_PORT_MODE +: 2];               // [R10]
    end
  end

  // master running flag; only a start trigger sets it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~array_power_enable)
      master_run <= 1'b0;                                      // [R3]
    else if (master_go)
      master_run <= 1'b1;                                      // [R12]
  end

  // master interval counter with reload at zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~array_power_enable)
      channel_down_counter <= 16'h0000;
    else if (master_go | m_reload)
      channel_down_counter <= master_period_value;             // [R16]
    else if (master_run & ch_tick[0])
      channel_down_counter <= channel_down_counter - 16'h0001; // [R16]
  end

  // master event: at start of counting and at each zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~array_power_enable)
      master_period_event <= 1'b0;
    else
      master_period_event <= master_go | m_reload;             // [R13] [R16]
  end

  // two identical slave channels
  mps_slave_ch u_slave1 (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_pwr     (array_power_enable),
    .i_start   (start_trig[1]),                                // [R12]
    .i_tick    (ch_tick[1]),
    .i_trig    (master_period_event),                          // [R14]
    .i_duty    (slave1_duty_value),
    .o_run     (slv_run[0]),
    .o_active  (slv_active[0]),
    .o_end     (slv_end[0]),
    .o_cnt     (slv_cnt[0])
  );

  mps_slave_ch u_slave2 (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_pwr     (array_power_enable),
    .i_start   (start_trig[2]),                                // [R12]
    .i_tick    (ch_tick[2]),
    .i_trig    (master_period_event),                          // [R14]
    .i_duty    (slave2_duty_value),
    .o_run     (slv_run[1]),
    .o_active  (slv_active[1]),
    .o_end     (slv_end[1]),
    .o_cnt     (slv_cnt[1])
  );

  // sticky interrupt status and mask
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | ~array_power_enable) begin
      irq_status <= RST_IRQ;
      irq_mask   <= RST_IRQ;
    end else begin
      irq_status <= next_irq_st;
      if (wr_imsk)
        irq_mask <= i_wdata[2:0];
    end
  end

  // registered outputs; irq tracks the status it will show
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_irq     <= 1'b0;
      o_pin_out <= 2'h0;
      o_pin_oe  <= 2'h0;
    end else begin
      o_irq     <= next_irq & array_power_enable;
      o_pin_out <= next_pin_out;
      o_pin_oe  <= next_pin_oe;
    end
  end

  // read data stand one cycle after the strobe, else zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst)
      o_rdata <= 32'h0;
    else
      o_rdata <= i_rd ? rd_mux : 32'h0;
  end

endmodule : mps_top

// File: testbench/mps_checker.sv
// mps_checker: port assertions for mps_top.
// assumes a bind from the bench top onto mps_top.
`timescale 1ns/100ps
module mps_checker
  import mps_pkg::*;
(
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  // register port
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // interrupt and pins
  input wire logic        o_irq,
  input wire logic [1:0]  o_pin_out,
  input wire logic [1:0]  o_pin_oe
);
  logic       pwr, go_any, go_all, msk0;
  logic [1:0] pm, lat;
  // write decode for the shadow state
  wire w_pe     = i_wr && i_addr == OFS_PER_EN;
  wire w_st     = i_wr && i_addr == OFS_START && pwr;
  wire w_pt     = i_wr && i_addr == OFS_PORT;
  wire w_mk     = i_wr && i_addr == OFS_IRQ_MSK && pwr;
  wire next_pwr = w_pe ? i_wdata[0] : pwr;
  wire rd_run   = i_rd && i_addr == OFS_RUN;
  // timer shadow; wiped on the same edge as the design powers off
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !next_pwr) begin
      go_any <= 1'b0;
      go_all <= 1'b0;
      msk0   <= 1'b0;
    end else begin
      go_any <= go_any | (w_st && |i_wdata[2:0]);
      go_all <= go_all | (w_st && i_wdata[2:0] == 3'h7);
      msk0   <= w_mk ? i_wdata[0] : msk0;
    end
  end
  // port register survives power off, so kept apart
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pwr <= 1'b0;
      pm  <= RST_PMODE;
      lat <= RST_LATCH;
    end else begin
      pwr <= next_pwr;
      pm  <= w_pt ? i_wdata[3:2] : pm;
      lat <= w_pt ? i_wdata[1:0] : lat;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // read data only in the slot after a read strobe
  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  start_reads_a: assert property (
    i_rd && i_addr == OFS_START |=> o_rdata == 32'h0)
    else $error("start register read back nonzero");
  unpowered_run_a: assert property (
    rd_run && !pwr |=> o_rdata == 32'h0)
    else $error("running flags set while unpowered");
  stopped_run_a: assert property (
    rd_run && pwr && !go_any |=> o_rdata == 32'h0)
    else $error("channel running before any start");
  started_run_a: assert property (
    rd_run && go_all |=> o_rdata[2:0] == 3'h7)
    else $error("running flags missing after start");
  irq_off_a: assert property (
    !pwr && !$past(pwr) |-> !o_irq)
    else $error("interrupt high while unpowered");
  pin_oe_a: assert property (
    o_pin_oe == ~$past(pm))
    else $error("pin drive does not follow port mode");
  latch_out_a: assert property (
    |$past(lat) |-> (o_pin_out & $past(lat)) == $past(lat))
    else $error("port latch one not seen on pin");
  master_irq_a: assert property (
    w_st && i_wdata[0] && msk0 |-> ##[1:5] o_irq)
    else $error("no interrupt after master start");
  // main scenarios reached
  start_all_c: cover property (w_st && i_wdata[2:0] == 3'h7);
  irq_rise_c: cover property ($rose(o_irq));
  pins_on_c: cover property (o_pin_oe == 2'h3 && |o_pin_out);
endmodule : mps_checker

// File: testbench/mps_pin_load.sv
// mps_pin_load: far-side load on the two slave wave pins.
// assumes oe high means the timer drives the pin.
`timescale 1ns/100ps
module mps_pin_load (
  // clock and control
  input  wire logic       i_ref_clk,
  input  wire logic       i_clr,
  // pins from the timer
  input  wire logic [1:0] i_out,
  input  wire logic [1:0] i_oe,
  // resolved level and high time
  output logic [1:0]      o_level,
  output int              o_high0,
  output int              o_high1
);
  // pull-downs hold a released pin low, never the last value
  assign o_level = i_out & i_oe;
  // high cycle tally, cleared by the bench between windows
  always @(posedge i_ref_clk) begin
    if (i_clr) begin
      o_high0 <= 0;
      o_high1 <= 0;
    end else begin
      o_high0 <= o_high0 + int'(o_level[0]);
      o_high1 <= o_high1 + int'(o_level[1]);
    end
  end
endmodule : mps_pin_load

// File: testbench/tb_multi_pwm_setup_and_start.sv
// tb_multi_pwm_setup_and_start: setup, start and pwm of mps_top.
// assumes mps_pkg offsets; pins load through mps_pin_load.
`timescale 1ns/100ps
module tb_multi_pwm_setup_and_start
  import mps_pkg::*;
();
  logic        clk, rst, wr, rd, clr, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  pout, poe, lvl;
  int          hi0, hi1, p, d1, d2, seed;
  int          err_count, n_compared;
  int          cyc = 0;
  // dut and pin load
  mps_top i_dut (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_irq(irq), .o_pin_out(pout), .o_pin_oe(poe));
  mps_pin_load i_load (.i_ref_clk(clk), .i_clr(clr), .i_out(pout),
    .i_oe(poe), .o_level(lvl), .o_high0(hi0), .o_high1(hi1));
  // 10 MHz clock
  initial clk = 1'b0;
  always #50 clk = ~clk;
  task automatic summarize;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // data stands only in the slot after the strobe edge
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd_reg
  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    {rst, wr, rd, clr, addr, wdata} = {4'b1000, 40'h0};
    {err_count, n_compared} = 64'h0;
    seed = 32'h561a;
    p  = 8 + ($random(seed) & 7);
    d1 = 1 + (($random(seed) & 255) % p);
    d2 = 1 + (($random(seed) & 255) % p);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // unpowered array drops timer writes
    wr_reg(OFS_PERIOD, p);
    rd_reg(OFS_RUN);
    chk(rv, 0);
    wr_reg(OFS_PER_EN, 1);
    rd_reg(OFS_PERIOD);
    chk(rv, RST_DATA);
    rd_reg(OFS_RUN);
    chk(rv, 0);
    rd_reg(8'hfc);
    chk(rv, 0);
    // channel setup with default level one, pins still port inputs
    wr_reg(OFS_PRESC, 0);
    wr_reg(OFS_MODE, 0);
    wr_reg(OFS_PERIOD, p);
    wr_reg(OFS_DUTY1, d1);
    wr_reg(OFS_DUTY2, d2);
    wr_reg(OFS_OUTCTL, 32'h33);
    repeat (2) @(posedge clk);
    #1 chk(poe, 0);
    wr_reg(OFS_PORT, 0);
    repeat (2) @(posedge clk);
    #1 chk({poe, lvl}, 32'hf);
    wr_reg(OFS_OUTCTL, 32'hf3);
    wr_reg(OFS_IRQ_MSK, 7);
    repeat (2) @(posedge clk);
    #1 chk(lvl, 3);
    // start all three and read the flags
    wr_reg(OFS_START, 7);
    rd_reg(OFS_START);
    chk(rv, 0);
    rd_reg(OFS_RUN);
    chk(rv, 7);
    rd_reg(OFS_IRQ_ST);
    chk(rv[0], 1);
    chk(irq, 1);
    rd_reg(OFS_MCOUNT);
    chk(rv <= p, 1);
    // high time over whole periods is phase independent
    repeat (2 * (p + 1)) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (4 * (p + 1)) @(posedge clk);
    #1 chk(hi0, 4 * d1);
    chk(hi1, 4 * d2);
    // power cycle, slow clock b on the master, interrupt paths
    wr_reg(OFS_PER_EN, 0);
    wr_reg(OFS_PER_EN, 1);
    rd_reg(OFS_RUN);
    chk(rv, 0);
    // a slave start alone must not count, even with duty one
    wr_reg(OFS_DUTY1, 1);
    wr_reg(OFS_START, 2);
    repeat (4) @(posedge clk);
    rd_reg(OFS_IRQ_ST);
    chk(rv, 0);
    rd_reg(OFS_RUN);
    chk(rv, 2);
    wr_reg(OFS_PRESC, 32'hf0);
    wr_reg(OFS_MODE, 1);
    wr_reg(OFS_IRQ_MSK, 1);
    wr_reg(OFS_START, 1);
    repeat (4) @(posedge clk);
    #1 chk(irq, 1);
    wr_reg(OFS_IRQ_MSK, 0);
    repeat (2) @(posedge clk);
    #1 chk(irq, 0);
    wr_reg(OFS_IRQ_ST, 1);
    rd_reg(OFS_IRQ_ST);
    chk(rv, 2);
    rd_reg(OFS_MCOUNT);
    chk(rv >= 32'hfffe, 1);
    wr_reg(OFS_PORT, 1);
    repeat (2) @(posedge clk);
    #1 chk(lvl[0], 1);
    summarize();
  end
endmodule : tb_multi_pwm_setup_and_start
bind mps_top mps_checker u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_irq(o_irq), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe));
